/* File: hdl/pbs_exec.sv */
/*
  executor for branch, sequence segment, diagnostic lamp and shift ops.
  assumes an apb master issues one instruction per write to the instr word;
  state bits live here, labels are resolved by a program-memory scanner
  outside via the jump request and label outputs.
*/
`timescale 1ns/1ps
module pbs_exec (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock enable
  input wire logic ce,
  // fault sources
  input wire logic forced_item,
  input wire logic module_io_error,
  input wire logic system_fault,
  input wire logic indirect_bad,
  // branch
  output logic branch_req,
  output logic [7:0] branch_label,
  // lamp
  output logic lamp_yellow,
  output logic lamp_red
);
  pbs_shift_if shb ();

  logic [1:0] ctrl_r;
  logic [31:0] opnd_r;
  logic [31:0] result_r;
  logic zero_r, ovf_r, eno_r;
  logic sstk_r, skip_r;
  logic lamp_r;
  logic [15:0] err_r;
  logic [31:0] sbits_r;
  logic [7:0] label_r;
  logic branch_r;
  logic [31:0] sbits_nxt;

  logic wr_en, rd_en;
  logic [31:0] rd_mux;
  logic addr_ok;
  logic ins_wr;
  pbs_pkg::pbs_op_type op;
  logic [7:0] ins_cnt, ins_arg;
  logic ins_pwr, ins_ind;
  logic [4:0] sidx;
  logic seg_active;
  logic is_shift, is_seg_op;
  logic [31:0] status_w;
  logic run_go, sh_go, sh_ok;

  function automatic logic [31:0] onehot(input logic [4:0] i);
    onehot = 32'h0000_0001 << i;
  endfunction

  assign wr_en = psel & penable & pwrite & ce;
  assign rd_en = psel & ~pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == pbs_pkg::CTRL_OFF) ||
                   (paddr == pbs_pkg::INSTR_OFF) ||
                   (paddr == pbs_pkg::OPND_OFF) ||
                   (paddr == pbs_pkg::RESULT_OFF) ||
                   (paddr == pbs_pkg::STATUS_OFF) ||
                   (paddr == pbs_pkg::SBITS_OFF) ||
                   (paddr == pbs_pkg::PC_OFF);
  assign pslverr = psel & penable & ~addr_ok;

  assign ins_wr = wr_en & (paddr == pbs_pkg::INSTR_OFF);
  assign op = pbs_pkg::pbs_op_type'(pwdata[pbs_pkg::INS_OP_POS +: 4]);
  assign ins_pwr = pwdata[pbs_pkg::INS_PWR_POS];
  assign ins_ind = pwdata[pbs_pkg::INS_IND_POS];
  assign ins_cnt = pwdata[pbs_pkg::INS_CNT_POS +: 8];
  assign ins_arg = pwdata[7:0];
  assign sidx = ins_arg[4:0];
  assign is_shift = (op == pbs_pkg::OP_SHL) || (op == pbs_pkg::OP_SHR);
  assign is_seg_op = (op == pbs_pkg::OP_SEG_LOAD) ||
                     (op == pbs_pkg::OP_SEG_END);
  // inside a de-energized or exited segment only segment load and end markers run
  assign seg_active = ~skip_r | is_seg_op;
  // qualified strobes shared by the checks below
  assign run_go = ins_wr & seg_active & ins_pwr;
  assign sh_go = run_go & is_shift;
  assign sh_ok = sh_go & ~ins_ind & ~indirect_bad;

  assign shb.din = opnd_r;
  assign shb.cnt = ins_cnt;
  assign shb.left = (op == pbs_pkg::OP_SHL);
  assign shb.wid = pbs_pkg::pbs_wid_type'(pwdata[pbs_pkg::INS_WID_POS +: 2]);

  pbs_shifter u_shift (
    .sh(shb.unit)
  );

  pbs_lamp u_lamp (
    .instr_on(lamp_r),
    .force_en(ctrl_r[pbs_pkg::CTRL_FORCE_EN_POS]),
    .forced(forced_item),
    .ioerr_en(ctrl_r[pbs_pkg::CTRL_IOERR_EN_POS]),
    .ioerr(module_io_error),
    .sys_fault(system_fault),
    .yellow(lamp_yellow),
    .red(lamp_red)
  );

  // transition clears own bit and sets target; set wins on same index
  always_comb begin
    sbits_nxt = sbits_r;
    if (ins_wr && seg_active && ins_pwr) begin
      if (op == pbs_pkg::OP_SEG_TRANS) begin
        sbits_nxt = (sbits_r & ~onehot(label_r[4:0])) | onehot(sidx);
      end else if (op == pbs_pkg::OP_SET_SBIT) begin
        sbits_nxt = sbits_r | onehot(sidx);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pbs_pkg::CTRL_RST;
      opnd_r <= pbs_pkg::WORD_ZERO;
    end else if (wr_en) begin
      if (paddr == pbs_pkg::CTRL_OFF) ctrl_r <= pwdata[1:0];
      if (paddr == pbs_pkg::OPND_OFF) opnd_r <= pwdata;
    end
  end

  // segment stack, active index and skip state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sstk_r <= 1'b0;
      skip_r <= 1'b0;
      sbits_r <= pbs_pkg::WORD_ZERO;
      label_r <= 8'h00;
    end else if (ins_wr) begin
      sbits_r <= sbits_nxt;
      case (op)
        pbs_pkg::OP_SEG_LOAD: begin
          sstk_r <= sbits_r[sidx];
          skip_r <= ~sbits_r[sidx];
          label_r <= ins_arg;
        end
        pbs_pkg::OP_SEG_END: begin
          skip_r <= 1'b0;
        end
        pbs_pkg::OP_SEG_CEXIT: begin
          // stack and state bits kept
          if (seg_active && ins_pwr) skip_r <= 1'b1;
        end
        default: begin
          // transition leaves stack alone
          sstk_r <= sstk_r;
        end
      endcase
    end
  end

  // shift results, lamp latch, branch requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= pbs_pkg::WORD_ZERO;
      zero_r <= 1'b0;
      ovf_r <= 1'b0;
      eno_r <= 1'b1;
      err_r <= pbs_pkg::ERR_NONE;
      lamp_r <= 1'b0;
      branch_r <= 1'b0;
      branch_label <= 8'h00;
    end else if (ce) begin
      branch_r <= 1'b0;
      if (ins_wr && seg_active) begin
        if (is_shift && ins_pwr) begin
          if (ins_ind || indirect_bad) begin
            eno_r <= 1'b0;
            err_r <= pbs_pkg::ERR_INDIRECT;
          end else begin
            eno_r <= 1'b1;
            err_r <= pbs_pkg::ERR_NONE;
            result_r <= shb.dout;
            zero_r <= shb.zero;
            if (ins_cnt != 8'h00) ovf_r <= shb.last_out;
          end
        end
        if (op == pbs_pkg::OP_LAMP && ins_pwr) begin
          lamp_r <= (opnd_r[7:0] != 8'h00);
        end
        if (op == pbs_pkg::OP_BRANCH && ins_pwr) begin
          branch_r <= 1'b1;
          branch_label <= ins_arg;
        end
      end
    end
  end
  assign branch_req = branch_r;

  assign status_w = {err_r, 8'h00, lamp_red, lamp_yellow, branch_r,
                     skip_r, sstk_r, eno_r, ovf_r, zero_r};
  assign rd_mux = (paddr == pbs_pkg::CTRL_OFF) ? {30'h0000_0000, ctrl_r} :
                  (paddr == pbs_pkg::OPND_OFF) ? opnd_r :
                  (paddr == pbs_pkg::RESULT_OFF) ? result_r :
                  (paddr == pbs_pkg::STATUS_OFF) ? status_w :
                  (paddr == pbs_pkg::SBITS_OFF) ? sbits_r :
                  (paddr == pbs_pkg::PC_OFF) ? {24'h00_0000, branch_label} :
                  pbs_pkg::WORD_ZERO;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= pbs_pkg::WORD_ZERO;
    else if (ce && rd_en && !penable) prdata <= rd_mux;
  end

  // checks share the decode strobes of the clocked blocks
  AST_ERR_CODE: assert property (
    @(posedge pclk) disable iff (!presetn)
    !eno_r |-> err_r == pbs_pkg::ERR_INDIRECT)
    else $error("enable low without indirect error code");
  AST_ENO_OK: assert property (
    @(posedge pclk) disable iff (!presetn)
    sh_ok |=> eno_r && err_r == pbs_pkg::ERR_NONE)
    else $error("clean shift left enable low");
  AST_ENO_BAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_go && !sh_ok) |=> !eno_r && err_r == pbs_pkg::ERR_INDIRECT)
    else $error("bad indirect shift kept enable high");
  AST_LAMP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r == pbs_pkg::CTRL_RST) |-> lamp_yellow == lamp_r)
    else $error("yellow not under sole instruction control");
  AST_LAMP_OPT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_r[pbs_pkg::CTRL_FORCE_EN_POS] && forced_item) |-> lamp_yellow)
    else $error("enabled forced item left yellow off");
  AST_LAMP_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_LAMP) |=>
      lamp_r == ($past(opnd_r[7:0]) != 8'h00))
    else $error("lamp latch does not follow byte");
  AST_RED: assert property (
    @(posedge pclk) disable iff (!presetn)
    lamp_red == system_fault)
    else $error("red lamp does not follow system fault");
  AST_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(zero_r) |-> result_r == pbs_pkg::WORD_ZERO)
    else $error("zero flag with nonzero result");
  AST_OVF_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && is_shift && ins_cnt == 8'h00) |=> $stable(ovf_r))
    else $error("overflow moved on zero count");
  AST_SH_COPY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_ok && ins_cnt == 8'h00 && shb.wid == pbs_pkg::WID_DWORD) |=>
      result_r == $past(opnd_r))
    else $error("zero count did not copy input");
  AST_SH_SAT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_ok && shb.wid == pbs_pkg::WID_BYTE && ins_cnt >= 8'h08) |=>
      result_r == pbs_pkg::WORD_ZERO)
    else $error("byte shift past width not cleared");
  AST_SH_FILL: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_ok && shb.left && ins_cnt == 8'h01) |=> !result_r[0])
    else $error("left shift did not fill with zero");
  AST_SH_NOSIGN: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_ok && !shb.left && shb.wid == pbs_pkg::WID_DWORD &&
      ins_cnt == 8'h01) |=> !result_r[31])
    else $error("right shift extended the sign");
  AST_SH_OVF: assert property (
    @(posedge pclk) disable iff (!presetn)
    (sh_ok && shb.left && shb.wid == pbs_pkg::WID_BYTE &&
      ins_cnt == 8'h01) |=> ovf_r == $past(opnd_r[7]))
    else $error("overflow is not the bit shifted out");
  AST_CEXIT: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && op == pbs_pkg::OP_SEG_CEXIT) |=>
      $stable(sbits_r) && $stable(sstk_r))
    else $error("conditional exit changed state");
  AST_CEXIT_SKIP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_SEG_CEXIT) |=> skip_r)
    else $error("conditional exit did not skip");
  AST_LOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && op == pbs_pkg::OP_SEG_LOAD) |=>
      sstk_r == $past(sbits_r[sidx]))
    else $error("segment load missed the state bit");
  AST_LOAD_SKIP: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && op == pbs_pkg::OP_SEG_LOAD) |=> skip_r == !sstk_r)
    else $error("segment energy does not follow stack");
  AST_SEG_END: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && op == pbs_pkg::OP_SEG_END) |=> !skip_r)
    else $error("logic after segment end still skipped");
  AST_SKIP_BODY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && skip_r && !is_seg_op) |=>
      $stable(sbits_r) && $stable(lamp_r) && $stable(result_r) &&
      !branch_req)
    else $error("skipped segment body took effect");
  AST_TRANS_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_SEG_TRANS) |=> sbits_r[$past(sidx)])
    else $error("transition did not set target bit");
  AST_TRANS_CLR: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_SEG_TRANS && sidx != label_r[4:0]) |=>
      !sbits_r[$past(label_r[4:0])])
    else $error("transition did not clear active bit");
  AST_TRANS_STK: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ins_wr && op == pbs_pkg::OP_SEG_TRANS) |=> $stable(sstk_r))
    else $error("transition changed the segment stack");
  AST_DIVERGE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_SEG_TRANS) |=>
      ($past(sbits_r) & ~sbits_r & ~$past(onehot(label_r[4:0]))) ==
      pbs_pkg::WORD_ZERO)
    else $error("transition dropped a diverging stream");
  AST_BRANCH: assert property (
    @(posedge pclk) disable iff (!presetn)
    (branch_req && ce) |=> !branch_req)
    else $error("branch request longer than one cycle");
  AST_BRANCH_LABEL: assert property (
    @(posedge pclk) disable iff (!presetn)
    (run_go && op == pbs_pkg::OP_BRANCH) |=>
      branch_req && branch_label == $past(ins_arg))
    else $error("branch request or label missing");
endmodule

/* File: hdl/pbs_lamp.sv */
/*
  lamp combiner: yellow from instruction or enabled fault options, red on fault.
  assumes all inputs synchronous to pclk.
*/
`timescale 1ns/1ps
module pbs_lamp (
  // instruction latch and fault options
  input wire logic instr_on,
  input wire logic force_en,
  input wire logic forced,
  input wire logic ioerr_en,
  input wire logic ioerr,
  input wire logic sys_fault,
  // lamp colours
  output logic yellow,
  output logic red
);
  assign yellow = instr_on | (force_en & forced) | (ioerr_en & ioerr);
  // red kept apart so both colours are visible to the lamp driver
  assign red = sys_fault;
endmodule

/* File: hdl/pbs_pkg.sv */
/*
  shared constants and types for the branch, sequence and shift executor.
  assumes a single clock domain driven by pclk.
*/
package pbs_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] INSTR_OFF = 12'h004;
  localparam logic [11:0] OPND_OFF = 12'h008;
  localparam logic [11:0] RESULT_OFF = 12'h00C;
  localparam logic [11:0] STATUS_OFF = 12'h010;
  localparam logic [11:0] SBITS_OFF = 12'h014;
  localparam logic [11:0] PC_OFF = 12'h018;
  // ctrl fields
  localparam int CTRL_FORCE_EN_POS = 0;
  localparam int CTRL_IOERR_EN_POS = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // instruction fields: op[31:28] width[27:26] n[15:8] arg[7:0]
  localparam int INS_OP_POS = 28;
  localparam int INS_WID_POS = 26;
  localparam int INS_IND_POS = 25;
  localparam int INS_PWR_POS = 24;
  localparam int INS_CNT_POS = 8;
  // status fields
  localparam int ST_ZERO_POS = 0;
  localparam int ST_OVF_POS = 1;
  localparam int ST_ENO_POS = 2;
  localparam int ST_SSTK_POS = 3;
  localparam int ST_SKIP_POS = 4;
  localparam int ST_JMP_POS = 5;
  localparam int ST_YEL_POS = 6;
  localparam int ST_RED_POS = 7;
  localparam int ST_ERR_POS = 16;
  localparam logic [15:0] ERR_INDIRECT = 16'h0006;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam int LABEL_MAX = 255;
  localparam int SBIT_COUNT = 32;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_BRANCH = 4'h1,
    OP_MARK = 4'h2,
    OP_SEG_LOAD = 4'h3,
    OP_SEG_END = 4'h4,
    OP_SEG_TRANS = 4'h5,
    OP_SEG_CEXIT = 4'h6,
    OP_LAMP = 4'h7,
    OP_SHL = 4'h8,
    OP_SHR = 4'h9,
    OP_SET_SBIT = 4'hA
  } pbs_op_type;

  typedef enum logic [1:0] {
    WID_BYTE = 2'h0,
    WID_WORD = 2'h1,
    WID_DWORD = 2'h2
  } pbs_wid_type;
endpackage

/* File: hdl/pbs_shift_if.sv */
/*
  carries one shift request and its answer between the core and the shifter.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface pbs_shift_if;
  logic [31:0] din;
  logic [7:0] cnt;
  logic left;
  pbs_pkg::pbs_wid_type wid;
  logic [31:0] dout;
  logic last_out;
  logic zero;
  modport core (output din, cnt, left, wid, input dout, last_out, zero);
  modport unit (input din, cnt, left, wid, output dout, last_out, zero);
endinterface

/* File: hdl/pbs_shifter.sv */
/*
  combinational zero-fill shifter for byte, word and double word.
  assumes operand bits above the width are ignored.
*/
`timescale 1ns/1ps
module pbs_shifter (
  pbs_shift_if.unit sh
);
  logic [5:0] eff;
  logic [5:0] wbits;
  logic [31:0] mask;
  logic [31:0] opnd;
  logic [63:0] wide;
  logic [63:0] moved;

  assign wbits = (sh.wid == pbs_pkg::WID_BYTE) ? 6'h08 :
                 (sh.wid == pbs_pkg::WID_WORD) ? 6'h10 : 6'h20;
  assign mask = (sh.wid == pbs_pkg::WID_BYTE) ? 32'h0000_00FF :
                (sh.wid == pbs_pkg::WID_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  // counts at or past the width saturate to the width
  assign eff = ({2'b00, sh.cnt} >= {4'h0, wbits}) ? wbits : sh.cnt[5:0];
  // unsigned view, no sign extension for any width
  assign opnd = sh.din & mask;
  assign wide = sh.left ? {32'h0000_0000, opnd} : {opnd, 32'h0000_0000};
  assign moved = sh.left ? (wide << eff) : (wide >> eff);
  assign sh.dout = sh.left ? (moved[31:0] & mask) : moved[63:32];
  // last bit out: left at bit width, right at bit 31 of low half
  assign sh.last_out = sh.left ? moved[wbits] : moved[31];
  assign sh.zero = (sh.dout == 32'h0000_0000);
endmodule

/* File: verification/pbs_exec_tb_top.sv */
/*
  bench for the executor: apb master, one task per scenario, verdict.
  assumes zero-wait apb answers and a program model on the branch outputs.
*/
`timescale 1ns/1ps
module pbs_exec_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic forced_item = 1'b0, module_io_error = 1'b0;
  logic system_fault = 1'b0, indirect_bad = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, branch_req, lamp_yellow, lamp_red;
  logic [7:0] branch_label, taken_cnt, resume_mark;
  int fail_count = 0;
  int cmp_count = 0;

  always #2.5 pclk = ~pclk;

  pbs_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce(ce),
    .forced_item(forced_item), .module_io_error(module_io_error),
    .system_fault(system_fault), .indirect_bad(indirect_bad),
    .branch_req(branch_req), .branch_label(branch_label),
    .lamp_yellow(lamp_yellow), .lamp_red(lamp_red));
  pbs_prog_model i_prog (.pclk(pclk), .presetn(presetn),
    .branch_req(branch_req), .branch_label(branch_label),
    .taken_cnt(taken_cnt), .resume_mark(resume_mark));

  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask

  // request held until pready is seen; bounded so a hang still reports
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      test_done();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e, m);
  endtask
  task automatic st(input logic [31:0] e, m);
    rdc(pbs_pkg::STATUS_OFF, e, m);
  endtask
  task automatic sb(input logic [31:0] e);
    rdc(pbs_pkg::SBITS_OFF, e, 32'hffff_ffff);
  endtask

  function automatic logic [31:0] ins(input logic [3:0] o,
      input logic [1:0] w, input logic ind, pw, input logic [7:0] c, g);
    return {o, w, ind, pw, 8'h00, c, g};
  endfunction
  task automatic ex(input logic [31:0] i);
    wr(pbs_pkg::INSTR_OFF, i);
  endtask
  task automatic op(input logic [3:0] o, input logic [7:0] g);
    ex(ins(o, 2'h0, 1'b0, 1'b1, 8'h00, g));
  endtask
  task automatic lamp(input logic [31:0] d);
    wr(pbs_pkg::OPND_OFF, d);
    op(pbs_pkg::OP_LAMP, 8'h00);
  endtask
  task automatic pins(input logic [1:0] e);
    @(posedge pclk);
    chk({30'h0000_0000, lamp_red, lamp_yellow}, 32'(e), 32'h0000_0003);
  endtask
  task automatic sh(input logic lf, input logic [1:0] w, input logic [7:0] c,
      input logic [31:0] d, r, input logic [1:0] oz);
    wr(pbs_pkg::OPND_OFF, d);
    ex(ins(lf ? pbs_pkg::OP_SHL : pbs_pkg::OP_SHR, w, 1'b0, 1'b1, c, 8'h00));
    rdc(pbs_pkg::RESULT_OFF, r, 32'hffff_ffff);
    st({29'h0000_0000, 1'b1, oz}, 32'h0000_0007);
  endtask

  task automatic t_reset();
    st(32'h0000_0004, 32'hffff_ffff);
    rdc(pbs_pkg::CTRL_OFF, 32'h0000_0000, 32'hffff_ffff);
    rdc(12'h0fc, 32'h0000_0000, 32'hffff_ffff);
    chk(32'(er), 32'h0000_0001, 32'h0000_0001);
  endtask

  task automatic t_branch();
    logic [7:0] l [2];
    logic [31:0] e;
    l = '{8'h00, 8'hff};
    for (int i = 0; i < 2; i++) begin
      op(pbs_pkg::OP_BRANCH, l[i]);
      op(pbs_pkg::OP_MARK, l[i]);
      repeat (2) @(posedge pclk);
      e = {16'h0000, 8'(i + 1), l[i]};
      chk({16'h0000, taken_cnt, resume_mark}, e, 32'h0000_ffff);
      rdc(pbs_pkg::PC_OFF, e, 32'h0000_00ff);
    end
  endtask

  task automatic t_seg();
    op(pbs_pkg::OP_SET_SBIT, 8'h03);
    op(pbs_pkg::OP_SEG_LOAD, 8'h03);
    st(32'h0000_0008, 32'h0000_0008);
    op(pbs_pkg::OP_SEG_TRANS, 8'h05);
    op(pbs_pkg::OP_SEG_TRANS, 8'h06);
    sb(32'h0000_0060);
    st(32'h0000_0008, 32'h0000_0008);
    wr(pbs_pkg::OPND_OFF, 32'h0000_0001);
    op(pbs_pkg::OP_SEG_CEXIT, 8'h00);
    sb(32'h0000_0060);
    st(32'h0000_0018, 32'h0000_0018);
    op(pbs_pkg::OP_LAMP, 8'h00);
    st(32'h0000_0000, 32'h0000_0040);
    op(pbs_pkg::OP_SEG_END, 8'h00);
    op(pbs_pkg::OP_SEG_LOAD, 8'h06);
    op(pbs_pkg::OP_LAMP, 8'h00);
    st(32'h0000_0040, 32'h0000_0040);
    op(pbs_pkg::OP_SEG_TRANS, 8'h07);
    sb(32'h0000_00a0);
    op(pbs_pkg::OP_SEG_END, 8'h00);
    op(pbs_pkg::OP_SEG_LOAD, 8'h06);
    lamp(32'h0000_0000);
    op(pbs_pkg::OP_SEG_TRANS, 8'h09);
    sb(32'h0000_00a0);
    st(32'h0000_0040, 32'h0000_0048);
    op(pbs_pkg::OP_SEG_END, 8'h00);
    op(pbs_pkg::OP_LAMP, 8'h00);
    st(32'h0000_0000, 32'h0000_0040);
  endtask

  task automatic t_lamp();
    lamp(32'h0000_0080);
    pins(2'b01);
    lamp(32'h0000_0000);
    pins(2'b00);
    forced_item <= 1'b1;
    module_io_error <= 1'b1;
    pins(2'b00);
    wr(pbs_pkg::CTRL_OFF, 32'h0000_0001);
    pins(2'b01);
    forced_item <= 1'b0;
    wr(pbs_pkg::CTRL_OFF, 32'h0000_0002);
    pins(2'b01);
    module_io_error <= 1'b0;
    system_fault <= 1'b1;
    pins(2'b10);
    system_fault <= 1'b0;
  endtask

  task automatic t_shift();
    sh(1'b1, 2'h0, 8'h01, 32'h0000_0081, 32'h0000_0002, 2'b10);
    sh(1'b0, 2'h0, 8'h04, 32'h0000_00f0, 32'h0000_000f, 2'b00);
    sh(1'b1, 2'h0, 8'hc8, 32'h0000_0081, 32'h0000_0000, 2'b11);
    sh(1'b0, 2'h1, 8'h01, 32'h0000_8000, 32'h0000_4000, 2'b00);
    sh(1'b1, 2'h1, 8'h10, 32'h0000_0001, 32'h0000_0000, 2'b11);
    sh(1'b0, 2'h2, 8'h1f, 32'h8000_0000, 32'h0000_0001, 2'b00);
    sh(1'b0, 2'h2, 8'h28, 32'h8000_0001, 32'h0000_0000, 2'b11);
    sh(1'b1, 2'h2, 8'h00, 32'h1234_5678, 32'h1234_5678, 2'b10);
  endtask

  task automatic t_ind();
    wr(pbs_pkg::OPND_OFF, 32'h0000_0001);
    ex(ins(pbs_pkg::OP_SHL, 2'h0, 1'b1, 1'b1, 8'h01, 8'h00));
    st(32'h0006_0000, 32'hffff_0004);
    sh(1'b1, 2'h0, 8'h01, 32'h0000_0001, 32'h0000_0002, 2'b00);
    indirect_bad <= 1'b1;
    ex(ins(pbs_pkg::OP_SHR, 2'h1, 1'b0, 1'b1, 8'h01, 8'h00));
    st(32'h0006_0000, 32'hffff_0004);
    indirect_bad <= 1'b0;
    // frozen clock enable must drop the write
    ce <= 1'b0;
    wr(pbs_pkg::OPND_OFF, 32'h0000_0055);
    ce <= 1'b1;
    rdc(pbs_pkg::OPND_OFF, 32'h0000_0001, 32'hffff_ffff);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_branch();
    t_seg();
    t_lamp();
    t_shift();
    t_ind();
    test_done();
  end
endmodule

/* File: verification/pbs_prog_model.sv */
/*
  program model: takes branch requests and resumes at the named mark.
  assumes one branch_req cycle for each executed branch.
*/
`timescale 1ns/1ps
module pbs_prog_model (
  // clock, reset
  input wire logic pclk,
  input wire logic presetn,
  // branch requests
  input wire logic branch_req,
  input wire logic [7:0] branch_label,
  // what the program saw
  output logic [7:0] taken_cnt,
  output logic [7:0] resume_mark
);
  // marks stay in the jump's own routine and segment
  // state bits used by this one routine only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken_cnt <= 8'h00;
      resume_mark <= 8'h00;
    end else if (branch_req) begin
      taken_cnt <= taken_cnt + 8'h01;
      resume_mark <= branch_label;
    end
  end
endmodule
